// ---- obc_ep_tracker.sv ----
// obc_ep_tracker: packet and byte bookkeeping for one OUT endpoint FIFO
// assumes: receive, pop and release strobes are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
module obc_ep_tracker
  import obc_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_rx_pkt,
  input  wire logic [7:0] i_rx_len,
  input  wire logic       i_dbl_buf,
  input  wire logic       i_byte_pop,
  input  wire logic       i_pkt_release,
  output logic      [1:0] o_buf_cnt,
  output logic      [7:0] o_first_cnt,
  output logic      [7:0] o_second_cnt,
  output logic            o_out_packet_ready_flag
);

  obc_state_t state_ff;
  obc_state_t nxt_state;
  logic [7:0] first_ff;
  logic [7:0] nxt_first;
  logic [7:0] second_ff;
  logic [7:0] nxt_second;
  logic       ready_ff;
  logic       nxt_ready;
  logic [1:0] bc_ff;
  logic [1:0] nxt_bc;

  // ********************************
  // next state
  // ********************************
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_first  = first_ff;
    nxt_second = second_ff;
    case (state_ff)
      OBC_ST_EMPTY:
      begin
        if (i_rx_pkt)
        begin
          nxt_first = i_rx_len;
          nxt_state = OBC_ST_ONE;
        end
      end
      OBC_ST_ONE:
      begin
        if (i_pkt_release)
        begin
          nxt_first = i_rx_pkt ? i_rx_len : 8'h00;
          nxt_state = i_rx_pkt ? OBC_ST_ONE : OBC_ST_EMPTY;
        end
        else if (i_rx_pkt && i_dbl_buf)
        begin
          nxt_second = i_rx_len;
          nxt_state  = OBC_ST_TWO;
        end
        else if (i_byte_pop && (first_ff != 8'h00))
        begin
          nxt_first = first_ff - 8'h01;
        end
      end
      OBC_ST_TWO:
      begin
        if (i_pkt_release)
        begin
          nxt_first  = second_ff;
          nxt_second = i_rx_pkt ? i_rx_len : 8'h00;
          nxt_state  = i_rx_pkt ? OBC_ST_TWO : OBC_ST_ONE;
        end
        else if (i_byte_pop && (first_ff != 8'h00))
        begin
          nxt_first = first_ff - 8'h01;
        end
      end
      default:
      begin
        nxt_state  = OBC_ST_EMPTY;
        nxt_first  = 8'h00;
        nxt_second = 8'h00;
      end
    endcase
    nxt_bc    = (nxt_state == OBC_ST_TWO) ? OBC_BC_TWO :
                (nxt_state == OBC_ST_ONE) ? OBC_BC_ONE : OBC_BC_NONE;
    nxt_ready = (nxt_state != OBC_ST_EMPTY);
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_ff  <= OBC_ST_EMPTY;
      first_ff  <= 8'h00;
      second_ff <= 8'h00;
      ready_ff  <= 1'b0;
      bc_ff     <= OBC_BC_NONE;
    end
    else
    begin
      state_ff  <= nxt_state;
      first_ff  <= nxt_first;
      second_ff <= nxt_second;
      ready_ff  <= nxt_ready;
      bc_ff     <= nxt_bc;
    end
  end

  assign o_buf_cnt               = bc_ff;
  assign o_first_cnt             = first_ff;
  assign o_second_cnt            = second_ff;
  assign o_out_packet_ready_flag = ready_ff;

endmodule // obc_ep_tracker
`default_nettype wire

// ---- obc_host_model.sv ----
// obc_host_model: usb host side, stores OUT packets into endpoint FIFOs
// assumes: one clock shared with the byte-count block
`timescale 1ns/100ps
`default_nettype none
module obc_host_model
(
  input  wire logic        i_sys_clk,
  output logic      [1:0]  o_rx_pkt,
  output logic      [15:0] o_rx_len
);
  initial
  begin
    o_rx_pkt = 2'h0;
    o_rx_len = 16'h0000;
  end

  // ********************************
  // packet delivery
  // ********************************
  // gap gives prompt or slow arrival
  task automatic send(input int ep, input logic [7:0] len, input int gap);
    repeat (gap) @(posedge i_sys_clk);
    o_rx_pkt[ep]         <= 1'b1;
    o_rx_len[ep*8 +: 8]  <= len;
    @(posedge i_sys_clk);
    o_rx_pkt[ep]         <= 1'b0;
    // length is stale now, so show its inverse
    o_rx_len[ep*8 +: 8]  <= ~len;
    @(posedge i_sys_clk);
  endtask
endmodule // obc_host_model
`default_nettype wire

// ---- obc_out_byte_count.sv ----
// obc_out_byte_count: APB-readable byte counts of OUT endpoints 1 and 2
// assumes: USB receive logic supplies packet/pop/release strobes per endpoint
//
// Notes on behaviour
// - with two packets held, upper field shows the second-stored packet's count.
// - buffer count 00b or 01b makes the upper field read zero.
// - with two packets held, lower field shows the first-stored packet's count.
// - with one packet held, lower field shows bytes still to unload.
// - while packet-ready is set, lower field tracks bytes awaiting unload, except a pop in the cycle a second packet is stored is lost.
// - endpoint 1 at 0x44, endpoint 2 at 0x48, both reset to zero.
`timescale 1ns/100ps
`default_nettype none
module obc_out_byte_count
  import obc_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_ep1_rx_pkt,
  input  wire logic [7:0]  i_ep1_rx_len,
  input  wire logic        i_ep1_dbl_buf,
  input  wire logic        i_ep1_byte_pop,
  input  wire logic        i_ep1_pkt_release,
  output logic             o_ep1_out_packet_ready_flag,
  input  wire logic        i_ep2_rx_pkt,
  input  wire logic [7:0]  i_ep2_rx_len,
  input  wire logic        i_ep2_dbl_buf,
  input  wire logic        i_ep2_byte_pop,
  input  wire logic        i_ep2_pkt_release,
  output logic             o_ep2_out_packet_ready_flag
);

  logic [1:0]  ep1_bc;
  logic [7:0]  ep1_first;
  logic [7:0]  ep1_second;
  logic [1:0]  ep2_bc;
  logic [7:0]  ep2_first;
  logic [7:0]  ep2_second;
  logic        setup;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        pready_ff;
  logic        nxt_pready;
  logic        pslverr_ff;
  logic        nxt_pslverr;

  // ********************************
  // endpoint trackers
  // ********************************
  obc_ep_tracker u_ep1
  (
    .i_sys_clk               (i_sys_clk),
    .i_rstn                  (i_rstn),
    .i_rx_pkt                (i_ep1_rx_pkt),
    .i_rx_len                (i_ep1_rx_len),
    .i_dbl_buf               (i_ep1_dbl_buf),
    .i_byte_pop              (i_ep1_byte_pop),
    .i_pkt_release           (i_ep1_pkt_release),
    .o_buf_cnt               (ep1_bc),
    .o_first_cnt             (ep1_first),
    .o_second_cnt            (ep1_second),
    .o_out_packet_ready_flag (o_ep1_out_packet_ready_flag)
  );

  obc_ep_tracker u_ep2
  (
    .i_sys_clk               (i_sys_clk),
    .i_rstn                  (i_rstn),
    .i_rx_pkt                (i_ep2_rx_pkt),
    .i_rx_len                (i_ep2_rx_len),
    .i_dbl_buf               (i_ep2_dbl_buf),
    .i_byte_pop              (i_ep2_byte_pop),
    .i_pkt_release           (i_ep2_pkt_release),
    .o_buf_cnt               (ep2_bc),
    .o_first_cnt             (ep2_first),
    .o_second_cnt            (ep2_second),
    .o_out_packet_ready_flag (o_ep2_out_packet_ready_flag)
  );

  // ********************************
  // apb slave
  // ********************************
  // data is captured in setup so the access phase never waits
  assign setup = i_psel && !i_penable;

  always_comb
  begin
    nxt_prdata  = prdata_ff;
    nxt_pready  = 1'b0;
    nxt_pslverr = 1'b0;
    if (setup)
    begin
      nxt_pready = 1'b1;
      nxt_prdata = OBC_RESET_VALUE;
      if (i_paddr == OBC_ADDR_EP1_RX_BYTE_COUNT)
      begin
        if (!i_pwrite)
        begin
          nxt_prdata = obc_pack_word(ep1_bc, ep1_first, ep1_second);
        end
      end
      else if (i_paddr == OBC_ADDR_EP2_RX_BYTE_COUNT)
      begin
        if (!i_pwrite)
        begin
          nxt_prdata = obc_pack_word(ep2_bc, ep2_first, ep2_second);
        end
      end
      else
      begin
        nxt_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      prdata_ff  <= OBC_RESET_VALUE;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign o_prdata  = prdata_ff;
  assign o_pready  = pready_ff;
  assign o_pslverr = pslverr_ff;

  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);

  a_second_cnt_two: assert property (
    (setup && !i_pwrite && i_paddr == OBC_ADDR_EP1_RX_BYTE_COUNT && ep1_bc == OBC_BC_TWO)
    |=> (o_prdata[23:16] == $past(ep1_second)) && o_pready)
    else $error("ep1 second count wrong with two packets");

  a_upper_zero_single: assert property (
    (setup && !i_pwrite && i_paddr == OBC_ADDR_EP2_RX_BYTE_COUNT && ep2_bc != OBC_BC_TWO)
    |=> o_prdata[23:16] == 8'h00)
    else $error("ep2 upper field not zero without two packets");

  a_first_cnt_read: assert property (
    (setup && !i_pwrite && i_paddr == OBC_ADDR_EP1_RX_BYTE_COUNT)
    |=> o_prdata[7:0] == $past(ep1_first))
    else $error("ep1 first count mismatch");

  a_pop_decrements: assert property (
    (ep1_bc == OBC_BC_ONE && i_ep1_byte_pop && !i_ep1_pkt_release && !i_ep1_rx_pkt
     && ep1_first != 8'h00)
    |=> ep1_first == $past(ep1_first) - 8'h01)
    else $error("ep1 count did not decrement on pop");

  a_count_held_ready: assert property (
    (o_ep2_out_packet_ready_flag && !i_ep2_byte_pop && !i_ep2_pkt_release)
    |=> $stable(ep2_first) && o_ep2_out_packet_ready_flag)
    else $error("ep2 count changed without unload");

  a_map_no_error: assert property (
    (setup && (i_paddr == OBC_ADDR_EP1_RX_BYTE_COUNT || i_paddr == OBC_ADDR_EP2_RX_BYTE_COUNT))
    |=> o_pready && !o_pslverr ##1 !o_pready)
    else $error("mapped access answered wrongly");

  a_unmapped_error: assert property (
    (setup && i_paddr != OBC_ADDR_EP1_RX_BYTE_COUNT && i_paddr != OBC_ADDR_EP2_RX_BYTE_COUNT)
    |=> o_pslverr && o_pready)
    else $error("unmapped access not flagged");

  a_reserved_zero: assert property (
    o_prdata[31:24] == 8'h00 && o_prdata[15:8] == 8'h00)
    else $error("reserved bits not zero");

  a_write_no_effect: assert property (
    (setup && i_pwrite && !i_ep1_rx_pkt && !i_ep1_byte_pop && !i_ep1_pkt_release)
    |=> $stable(ep1_first) && $stable(ep1_bc))
    else $error("write altered ep1 count");

  a_ep2_second_cnt: assert property (
    (setup && !i_pwrite && i_paddr == OBC_ADDR_EP2_RX_BYTE_COUNT && ep2_bc == OBC_BC_TWO)
    |=> o_prdata[23:16] == $past(ep2_second))
    else $error("ep2 second count wrong with two packets");

  a_ep1_upper_zero: assert property (
    (setup && !i_pwrite && i_paddr == OBC_ADDR_EP1_RX_BYTE_COUNT && ep1_bc != OBC_BC_TWO)
    |=> o_prdata[23:16] == 8'h00)
    else $error("ep1 upper field not zero without two packets");

  a_ep2_first_cnt: assert property (
    (setup && !i_pwrite && i_paddr == OBC_ADDR_EP2_RX_BYTE_COUNT)
    |=> o_prdata[7:0] == $past(ep2_first))
    else $error("ep2 first count mismatch");

  // second packet moves down when the first is released
  a_release_shift: assert property (
    (ep1_bc == OBC_BC_TWO && i_ep1_pkt_release && !i_ep1_rx_pkt)
    |=> ep1_first == $past(ep1_second) && ep1_bc == OBC_BC_ONE)
    else $error("ep1 release did not move second packet down");

  a_flag_clears: assert property (
    (ep1_bc == OBC_BC_ONE && i_ep1_pkt_release && !i_ep1_rx_pkt)
    |=> !o_ep1_out_packet_ready_flag && ep1_first == 8'h00)
    else $error("ep1 ready flag stayed set after last release");

  a_unmapped_data_zero: assert property (
    (setup && !i_pwrite && i_paddr != OBC_ADDR_EP1_RX_BYTE_COUNT
     && i_paddr != OBC_ADDR_EP2_RX_BYTE_COUNT)
    |=> o_prdata == OBC_RESET_VALUE)
    else $error("unmapped read returned data");

  c_ep1_two_packets: cover property (ep1_bc == OBC_BC_TWO ##1 i_ep1_pkt_release);
  c_ep2_read_two: cover property (setup && i_paddr == OBC_ADDR_EP2_RX_BYTE_COUNT
                                  && ep2_bc == OBC_BC_TWO);
  c_unmapped: cover property (o_pslverr);
  c_release_with_rx: cover property (i_ep1_pkt_release && i_ep1_rx_pkt);
  c_ep1_pop: cover property (i_ep1_byte_pop && ep1_bc == OBC_BC_ONE);

endmodule // obc_out_byte_count
`default_nettype wire

// ---- obc_out_byte_count_tb_top.sv ----
// obc_out_byte_count_tb_top: register-level checks of both OUT endpoints
// assumes: single 20 MHz clock, apb master driven from this bench
`timescale 1ns/100ps
`default_nettype none
module obc_out_byte_count_tb_top;
  logic        sys_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  rx_pkt, dbl, pop, rel, flag;
  logic [15:0] rx_len;
  int          errors, samples_checked, cyc;

  obc_host_model i_obc_host_model (.i_sys_clk(sys_clk), .o_rx_pkt(rx_pkt), .o_rx_len(rx_len));
  obc_out_byte_count i_obc_out_byte_count (.i_sys_clk(sys_clk), .i_rstn(rstn),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_ep1_rx_pkt(rx_pkt[0]), .i_ep1_rx_len(rx_len[7:0]), .i_ep1_dbl_buf(dbl[0]),
    .i_ep1_byte_pop(pop[0]), .i_ep1_pkt_release(rel[0]),
    .o_ep1_out_packet_ready_flag(flag[0]),
    .i_ep2_rx_pkt(rx_pkt[1]), .i_ep2_rx_len(rx_len[15:8]), .i_ep2_dbl_buf(dbl[1]),
    .i_ep2_byte_pop(pop[1]), .i_ep2_pkt_release(rel[1]),
    .o_ep2_out_packet_ready_flag(flag[1]));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ********************************
  // shared tasks
  // ********************************
  task automatic test_done();
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // waits as long as the slave needs; only the bench timeout ends it
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle edge so a following call never re-drives psel in this step
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk("prdata", exp, r);
    chk("pslverr", {31'h0, experr}, {31'h0, e});
  endtask

  task automatic strobe(input int ep, input logic release_pkt);
    if (release_pkt)
      rel[ep] <= 1'b1;
    else
      pop[ep] <= 1'b1;
    @(posedge sys_clk);
    rel <= 2'h0;
    pop <= 2'h0;
    @(posedge sys_clk);
  endtask

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      test_done();
    end
  end

  // ********************************
  // main sequence
  // ********************************
  initial
  begin
    logic [11:0] a;
    logic [7:0]  l1, l2;
    logic [31:0] r;
    logic        e;
    {rstn, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata, dbl, pop, rel} = 50'h0;
    errors = 0;
    samples_checked = 0;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    for (int ep = 0; ep < 2; ep++)
    begin
      a  = (ep == 0) ? 12'h044 : 12'h048;
      l1 = (ep == 0) ? 8'h05 : 8'hFF;
      l2 = (ep == 0) ? 8'h07 : 8'h01;
      rd(a, 32'h0000_0000, 1'b0);
      i_obc_host_model.send(ep, l1, ep * 3);
      rd(a, {24'h0, l1}, 1'b0);
      chk("ready flag", 32'h1, {31'h0, flag[ep]});
      // single buffering refuses a second packet
      i_obc_host_model.send(ep, 8'h09, 0);
      rd(a, {24'h0, l1}, 1'b0);
      strobe(ep, 1'b0);
      strobe(ep, 1'b0);
      rd(a, {24'h0, l1 - 8'h02}, 1'b0);
      dbl[ep] <= 1'b1;
      i_obc_host_model.send(ep, l2, 0);
      rd(a, {8'h0, l2, 8'h0, l1 - 8'h02}, 1'b0);
      apb(1'b1, a, 32'hFFFF_FFFF, r, e);
      chk("pslverr", 32'h0, {31'h0, e});
      rd(a, {8'h0, l2, 8'h0, l1 - 8'h02}, 1'b0);
      strobe(ep, 1'b1);
      rd(a, {24'h0, l2}, 1'b0);
      strobe(ep, 1'b1);
      rd(a, 32'h0000_0000, 1'b0);
      chk("ready flag", 32'h0, {31'h0, flag[ep]});
    end
    // release and a new packet in one cycle: new packet becomes the only one
    i_obc_host_model.send(0, 8'h10, 0);
    fork
      strobe(0, 1'b1);
      i_obc_host_model.send(0, 8'h20, 0);
    join
    rd(12'h044, 32'h0000_0020, 1'b0);
    chk("ready flag", 32'h1, {31'h0, flag[0]});
    rd(12'h04C, 32'h0000_0000, 1'b1);
    test_done();
  end
endmodule // obc_out_byte_count_tb_top
`default_nettype wire

// ---- obc_pkg.sv ----
// obc_pkg: constants shared by the OUT endpoint byte-count block
// assumes: 32-bit APB data, byte addressed, registers on aligned words
`default_nettype none
package obc_pkg;

  // ********************************
  // register map
  // ********************************
  localparam logic [11:0] OBC_ADDR_EP1_RX_BYTE_COUNT = 12'h044;
  localparam logic [11:0] OBC_ADDR_EP2_RX_BYTE_COUNT = 12'h048;
  localparam logic [31:0] OBC_RESET_VALUE            = 32'h0000_0000;

  // ********************************
  // field layout
  // ********************************
  localparam int          OBC_FIRST_LSB  = 0;
  localparam int          OBC_SECOND_LSB = 16;
  localparam logic [7:0]  OBC_RESERVED_BITS_ZERO  = 8'h00;

  // buffer-count codes as seen in the endpoint control/status register
  localparam logic [1:0]  OBC_BC_NONE = 2'h0;
  localparam logic [1:0]  OBC_BC_ONE  = 2'h1;
  localparam logic [1:0]  OBC_BC_TWO  = 2'h3;

  typedef enum logic [2:0]
  {
    OBC_ST_EMPTY = 3'b001,
    OBC_ST_ONE   = 3'b010,
    OBC_ST_TWO   = 3'b100
  } obc_state_t;

  // packs one count register word; second count only shown with two packets
  function automatic logic [31:0] obc_pack_word
  (
    input logic [1:0] bc,
    input logic [7:0] first_cnt,
    input logic [7:0] second_cnt
  );
    logic [7:0] upper;
    upper = (bc == OBC_BC_TWO) ? second_cnt : OBC_RESERVED_BITS_ZERO;
    obc_pack_word = {OBC_RESERVED_BITS_ZERO, upper, OBC_RESERVED_BITS_ZERO, first_cnt};
  endfunction

endpackage
`default_nettype wire
